//--- rtl/pors_pkg.sv
// Purpose: Shared constants and types for the power-on reset sequencer
// Assumes: 20 MHz oscillator clock
// Notes:   Phase lengths in oscillator cycles
`default_nettype none
package pors_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned FILT_MIN_NS   = 475;
   localparam int unsigned FILT_MAX_NS   = 2000;
   // Longest ignored pulse rounds down, shortest taken pulse rounds up
   localparam int unsigned FILT_REJ_CYC  = FILT_MIN_NS / CLK_PERIOD_NS;
   localparam int unsigned FILT_ACC_CYC  = (FILT_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0]  FILT_CYC      = 6'(FILT_REJ_CYC + 1);
   localparam logic [11:0] OSC_CYC       = 12'h408;
   localparam logic [11:0] FUSE_CYC      = 12'h488;
   localparam logic [11:0] PUMP_CYC      = 12'h2b0;
   localparam logic [11:0] BANK_CYC      = 12'h269;
   localparam logic [11:0] WARM_CYC      = 12'h8d0;
   localparam logic [31:0] BOOT_ADDR     = 32'h0000_0000;
   localparam logic [5:0]  FILT_RST      = 6'h00;
   localparam logic [11:0] CNT_RST       = 12'h000;

   typedef enum logic [2:0] {
      PH_IDLE, PH_OSC, PH_FUSE, PH_PUMP, PH_BANK, PH_RUN
   } pors_phase_e;

   typedef struct packed {
      logic coreOk;
      logic ioOk;
      logic lowPower;
   } pors_supply_s;

   typedef struct packed {
      logic oscEnable;
      logic fuseLoad;
      logic pumpOn;
      logic bankOn;
   } pors_phase_s;
endpackage
`default_nettype wire

//--- rtl/pors_filter.sv
// Purpose: Glitch filter for the active-low power-on reset pin
// Assumes: Pin already synchronous to clock
// Notes:   Low must persist FILT_CYC + 1 cycles before it is taken
`default_nettype none
module pors_filter (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Pin and filtered level
   input  wire logic pinLow,
   output var  logic resetReq
);
   logic [5:0] count;
   logic [5:0] next_count;
   logic       next_resetReq;

   always_comb begin
      next_count    = count;
      next_resetReq = resetReq;
      if (!pinLow) begin
         next_count    = pors_pkg::FILT_RST;
         next_resetReq = 1'b0;
      end else if (count != pors_pkg::FILT_CYC) begin
         next_count = count + 6'h01;
      end else begin
         next_resetReq = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count    <= pors_pkg::FILT_RST;
         resetReq <= 1'b1;
      end else begin
         count    <= next_count;
         resetReq <= next_resetReq;
      end
   end
endmodule
`default_nettype wire

//--- rtl/pors_sequencer.sv
// Purpose: Power-on reset and start-up phase sequencer
// Assumes: Analog comparators give supply levels synchronous to clock
// Notes:   Core supply fault tri-states pins without a clock
//
// Contract
// RL1: Power-good outputs low when any supply low
// RL2: Isolate core and I/O while power-good low
// RL3: Low I/O supply asserts internal power-on reset
// RL4: Core fault: async pin tri-state, assert reset
// RL5: Supply monitor disabled in low power mode
// RL6: Start only with supplies good, reset released
// RL7: Oscillator 1032 cycles, then fuse 1160
// RL8: Then pump 688, then bank 617
// RL9: CPU reset released after last phase
// RL10: Supervisor holds reset pin low when out-of-range
// RL11: Filter ignores 475 ns, takes 2000 ns
// RL12: Warm reset low 2256 cycles after release
// RL13: Any reset cause aborts and restarts
// RL14: One phase counter, advance after full count
`default_nettype none
module pors_sequencer (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst,
   // Supply monitor comparators and mode
   input  wire pors_pkg::pors_supply_s supply,
   // Power-on reset pin, active low
   input  wire logic                  powerOnResetN,
   // Warm reset open-drain pin
   input  wire logic                  warmResetNIn,
   output var  logic                  warmResetNOut,
   output var  logic                  warmResetNOe,
   // Power-good and isolation
   output var  logic                  corePowerGood,
   output var  logic                  ioPowerGood,
   output var  logic                  isolate,
   output var  logic                  pinsHighZ,
   // Phase controls and CPU
   output var  pors_pkg::pors_phase_s phaseCtl,
   output var  logic                  cpuResetN,
   output var  logic [31:0]           bootAddr
);
   logic                  pinReq;
   logic                  coreFault;
   logic                  ioFault;
   logic                  porCause;
   pors_pkg::pors_phase_e phase;
   pors_pkg::pors_phase_e next_phase;
   logic [11:0]           count;
   logic [11:0]           next_count;
   logic [11:0]           warmCount;
   logic [11:0]           next_warmCount;
   logic                  next_corePowerGood;
   logic                  next_ioPowerGood;
   logic                  next_cpuResetN;
   logic                  next_warmResetNOe;
   pors_pkg::pors_phase_s next_phaseCtl;
   logic                  coreFaultHz;

   function automatic logic [11:0] phaseLen(input pors_pkg::pors_phase_e p);
      case (p)
         pors_pkg::PH_OSC:  phaseLen = pors_pkg::OSC_CYC;
         pors_pkg::PH_FUSE: phaseLen = pors_pkg::FUSE_CYC;
         pors_pkg::PH_PUMP: phaseLen = pors_pkg::PUMP_CYC;
         pors_pkg::PH_BANK: phaseLen = pors_pkg::BANK_CYC;
         default:           phaseLen = 12'h001;
      endcase
   endfunction

   pors_filter u_filter (
      .clock    (clock),
      .rst      (rst),
      .pinLow   (~powerOnResetN),
      .resetReq (pinReq)
   ); // see RL11

   // Monitor is blind in low power mode
   assign coreFault = ~supply.coreOk & ~supply.lowPower; // see RL5
   assign ioFault   = ~supply.ioOk & ~supply.lowPower;   // see RL5
   assign porCause  = coreFault | ioFault | pinReq;      // see RL3

   // Power-good and CPU/warm reset state
   always_comb begin
      next_corePowerGood = ~(coreFault | ioFault); // see RL1
      next_ioPowerGood   = ~(coreFault | ioFault); // see RL1
      next_cpuResetN     = (phase == pors_pkg::PH_RUN) && !porCause; // see RL9
      next_warmCount     = warmCount;
      next_warmResetNOe  = 1'b1;
      if (porCause) begin
         next_warmCount = pors_pkg::CNT_RST;
      end else if (warmCount != pors_pkg::WARM_CYC) begin
         next_warmCount = warmCount + 12'h001;
      end else begin
         next_warmResetNOe = 1'b0; // see RL12
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         corePowerGood <= 1'b0;
         ioPowerGood   <= 1'b0;
         isolate       <= 1'b1;
         cpuResetN     <= 1'b0;
         warmCount     <= pors_pkg::CNT_RST;
         warmResetNOe  <= 1'b1;
      end else begin
         corePowerGood <= next_corePowerGood;
         ioPowerGood   <= next_ioPowerGood;
         isolate       <= ~(next_corePowerGood & next_ioPowerGood); // see RL2
         cpuResetN     <= next_cpuResetN;
         warmCount     <= next_warmCount;
         warmResetNOe  <= next_warmResetNOe;
      end
   end

   // Open drain drives only low
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         warmResetNOut <= 1'b0;
         bootAddr      <= pors_pkg::BOOT_ADDR;
      end else begin
         warmResetNOut <= 1'b0;
         bootAddr      <= pors_pkg::BOOT_ADDR; // see RL9
      end
   end

   // Core fault forces high impedance without a clock
   always_ff @(posedge clock or posedge coreFault) begin
      if (coreFault) begin
         coreFaultHz <= 1'b1; // see RL4
      end else begin
         coreFaultHz <= 1'b0;
      end
   end
   assign pinsHighZ = coreFaultHz;

   // Phase sequencer with a single counter
   always_comb begin
      next_phase = phase;
      next_count = count;
      if (porCause) begin
         next_phase = pors_pkg::PH_IDLE; // see RL13
         next_count = pors_pkg::CNT_RST;
      end else begin
         case (phase)
            pors_pkg::PH_IDLE: begin
               next_phase = pors_pkg::PH_OSC; // see RL6
               next_count = pors_pkg::CNT_RST;
            end
            pors_pkg::PH_OSC, pors_pkg::PH_FUSE, pors_pkg::PH_PUMP, pors_pkg::PH_BANK: begin
               if (count == phaseLen(phase) - 12'h001) begin // see RL14
                  next_count = pors_pkg::CNT_RST;
                  case (phase)
                     pors_pkg::PH_OSC:  next_phase = pors_pkg::PH_FUSE; // see RL7
                     pors_pkg::PH_FUSE: next_phase = pors_pkg::PH_PUMP; // see RL8
                     pors_pkg::PH_PUMP: next_phase = pors_pkg::PH_BANK; // see RL8
                     default:           next_phase = pors_pkg::PH_RUN;  // see RL9
                  endcase
               end else begin
                  next_count = count + 12'h001;
               end
            end
            pors_pkg::PH_RUN: next_phase = pors_pkg::PH_RUN;
            default: next_phase = pors_pkg::PH_IDLE;
         endcase
      end
      next_phaseCtl.oscEnable = next_phase != pors_pkg::PH_IDLE;
      next_phaseCtl.fuseLoad  = next_phase == pors_pkg::PH_FUSE;
      next_phaseCtl.pumpOn    = next_phase inside {pors_pkg::PH_PUMP, pors_pkg::PH_BANK,
                                                   pors_pkg::PH_RUN};
      next_phaseCtl.bankOn    = next_phase inside {pors_pkg::PH_BANK, pors_pkg::PH_RUN};
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase    <= pors_pkg::PH_IDLE;
         count    <= pors_pkg::CNT_RST;
         phaseCtl <= '0;
      end else begin
         phase    <= next_phase;
         count    <= next_count;
         phaseCtl <= next_phaseCtl;
      end
   end

   // Assertions
   a_pg_low_fault: assert property (@(posedge clock) disable iff (rst) // see RL1
      (coreFault | ioFault) |=> !corePowerGood && !ioPowerGood)
      else $error("power good high during supply fault");
   a_iso_pg: assert property (@(posedge clock) disable iff (rst) // see RL2
      (!corePowerGood || !ioPowerGood) |-> isolate)
      else $error("not isolated while power good low");
   a_io_reset: assert property (@(posedge clock) disable iff (rst) // see RL3
      ioFault |=> phase == pors_pkg::PH_IDLE && !cpuResetN)
      else $error("io fault did not reset");
   a_core_hiz: assert property (@(posedge clock) disable iff (rst) // see RL4
      coreFault |-> pinsHighZ)
      else $error("pins not high impedance on core fault");
   a_lp_quiet: assert property (@(posedge clock) disable iff (rst) // see RL5
      supply.lowPower && !pinReq |=> corePowerGood)
      else $error("monitor active in low power");
   a_start_cond: assert property (@(posedge clock) disable iff (rst) // see RL6
      $rose(phase == pors_pkg::PH_OSC) |-> $past(!porCause))
      else $error("start without good supplies");
   a_osc_len: assert property (@(posedge clock) disable iff (rst) // see RL7
      (phase == pors_pkg::PH_OSC && !porCause)
      |=> (phase == pors_pkg::PH_FUSE) == ($past(count) == pors_pkg::OSC_CYC - 12'h001))
      else $error("oscillator phase length wrong");
   a_order: assert property (@(posedge clock) disable iff (rst) // see RL8
      (phase == pors_pkg::PH_BANK) |-> $past(phase) inside {pors_pkg::PH_PUMP,
                                                           pors_pkg::PH_BANK})
      else $error("bank phase out of order");
   a_cpu_rel: assert property (@(posedge clock) disable iff (rst) // see RL9
      $rose(cpuResetN) |-> $past(phase) == pors_pkg::PH_RUN)
      else $error("cpu released early");
   a_warm_hold: assert property (@(posedge clock) disable iff (rst) // see RL12
      $fell(warmResetNOe) |-> $past(warmCount) == pors_pkg::WARM_CYC)
      else $error("warm reset released early");
   a_abort: assert property (@(posedge clock) disable iff (rst) // see RL13
      porCause |=> !cpuResetN ##0 phase == pors_pkg::PH_IDLE)
      else $error("no abort on reset cause");
   a_one_step: assert property (@(posedge clock) disable iff (rst) // see RL14
      (phase != $past(phase) && phase != pors_pkg::PH_IDLE && $past(phase) != pors_pkg::PH_IDLE)
      |-> $past(count) == phaseLen($past(phase)) - 12'h001)
      else $error("phase advanced early");
endmodule
`default_nettype wire

//--- dv/pors_supervisor.sv
// Purpose: External reset supervisor model driving the power-on reset pin
// Assumes: Updates on the falling edge, pulse request sampled there
// Notes:   Tracking can be switched off to leave supply faults to the device
`default_nettype none
module pors_supervisor (
   // Clock
   input  wire logic                   clock,
   // Supply levels and controls
   input  wire pors_pkg::pors_supply_s supply,
   input  wire logic                   track,
   input  wire logic [5:0]             pulseLen,
   input  wire logic                   pulseGo,
   // Pin, active low
   output var  logic                   powerOnResetN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] left = 6'h00;

   // Low pulse of pulseLen cycles
   always @(negedge clock) begin
      if (pulseGo)
         left <= pulseLen;
      else if (left != 6'h00)
         left <= left - 6'h01;
   end

   // Held low while supplies are out of range
   always_comb begin
      powerOnResetN = (left == 6'h00) & (~track | (supply.coreOk & supply.ioOk));
   end
endmodule
`default_nettype wire

//--- dv/tb.sv
// Purpose: Self-checking bench for the power-on reset sequencer
// Assumes: 50 ns clock, supply driven on the falling edge, pulse request on the rising edge
// Notes:   Supply rows first, then sequence, filter, warm reset and abort
`default_nettype none
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, (a), (b)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [2:0] sup;
      logic [3:0] res;
   } pors_row_s;
   logic clock, rst, warmResetNOut, warmResetNOe, corePowerGood, ioPowerGood;
   logic isolate, pinsHighZ, cpuResetN, powerOnResetN, pulseGo, track;
   logic [5:0] pulseLen;
   logic [31:0] bootAddr;
   wire logic warmResetNIn;
   pors_pkg::pors_supply_s supply;
   pors_pkg::pors_phase_s  phaseCtl;
   int miscompares = 0;
   int checkCount = 0;
   int n;
   // Bank pattern lasts into the run cycle before the CPU is let go
   int phaseLen [4] = '{1032, 1160, 688, 618};
   logic [3:0] phasePat [4] = '{4'h8, 4'hc, 4'ha, 4'hb};
   pors_row_s rows [7] = '{'{3'b010, 4'b0011}, '{3'b110, 4'b1100}, '{3'b100, 4'b0010},
      '{3'b000, 4'b0011}, '{3'b011, 4'b1100}, '{3'b101, 4'b1100}, '{3'b111, 4'b1100}};

   // Open-drain pin with pull-up
   assign warmResetNIn = warmResetNOe ? warmResetNOut : 1'b1;

   pors_sequencer i_pors_sequencer (.clock(clock), .rst(rst), .supply(supply),
      .powerOnResetN(powerOnResetN), .warmResetNIn(warmResetNIn),
      .warmResetNOut(warmResetNOut), .warmResetNOe(warmResetNOe),
      .corePowerGood(corePowerGood), .ioPowerGood(ioPowerGood), .isolate(isolate),
      .pinsHighZ(pinsHighZ), .phaseCtl(phaseCtl), .cpuResetN(cpuResetN),
      .bootAddr(bootAddr));
   pors_supervisor i_pors_supervisor (.clock(clock), .supply(supply), .track(track),
      .pulseLen(pulseLen), .pulseGo(pulseGo), .powerOnResetN(powerOnResetN));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic report_and_stop();
      if (miscompares == 0 && checkCount > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic pulse(input logic [5:0] len);
      @(posedge clock);
      pulseLen <= len;
      pulseGo <= 1'b1;
      @(posedge clock);
      pulseGo <= 1'b0;
      @(negedge clock);
   endtask

   // Full start-up walk with phase lengths
   task automatic run_seq();
      int k;
      k = 0;
      supply = 3'b000;
      @(negedge clock);
      supply = 3'b110;
      while (phaseCtl.oscEnable !== 1'b1 && k < 3000) begin
         k++;
         @(negedge clock);
      end
      for (int i = 0; i < 4; i++) begin
         k = 0;
         `CHK(4'(phaseCtl), phasePat[i])
         `CHK(cpuResetN, 1'b0)
         while (4'(phaseCtl) === phasePat[i] && cpuResetN === 1'b0 && k < 2000) begin
            k++;
            @(negedge clock);
         end
         `CHK(k, phaseLen[i])
      end
      repeat (2) @(negedge clock);
      `CHK(cpuResetN, 1'b1)
      `CHK(bootAddr, 32'h0000_0000)
      `CHK({isolate, 4'(phaseCtl)}, 5'h0b)
   endtask

   initial begin
      rst = 1'b1;
      supply = 3'b110;
      track = 1'b0;
      pulseGo = 1'b0;
      pulseLen = 6'h00;
      repeat (4) @(negedge clock);
      rst = 1'b0;
      foreach (rows[i]) begin
         @(negedge clock);
         supply = rows[i].sup;
         #1;
         if (rows[i].res[0]) `CHK(pinsHighZ, 1'b1)
         repeat (3) @(negedge clock);
         `CHK({corePowerGood, ioPowerGood, isolate, pinsHighZ}, rows[i].res)
         if (!rows[i].res[3]) `CHK({cpuResetN, 4'(phaseCtl)}, 5'h00)
      end
      supply = 3'b110;
      track = 1'b1;
      run_seq();
      // Short low pulse ignored, longer one taken
      pulse(6'd10);
      repeat (20) @(negedge clock);
      `CHK(cpuResetN, 1'b1)
      pulse(6'd41);
      n = 0;
      while (powerOnResetN !== 1'b1 && n < 60) begin
         n++;
         @(negedge clock);
      end
      `CHK(cpuResetN, 1'b0)
      n = 0;
      while (warmResetNOe === 1'b1 && n < 3000) begin
         n++;
         @(negedge clock);
      end
      `CHK(n >= 2256 && n <= 2260, 1'b1)
      run_seq();
      // Abort inside the fuse phase
      supply = 3'b010;
      repeat (10) @(negedge clock);
      supply = 3'b110;
      repeat (1500) @(negedge clock);
      `CHK(phaseCtl.fuseLoad, 1'b1)
      pulse(6'd20);
      repeat (16) @(negedge clock);
      `CHK({cpuResetN, warmResetNOe, 4'(phaseCtl)}, 6'h10)
      run_seq();
      report_and_stop();
   end

   initial begin
      repeat (60000) @(posedge clock);
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
